/* File: rtl/burst_write_fifo.sv */
// synchronous fifo with valid/ready on both sides and a fill level
`timescale 1ns/1ps
module burst_write_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW:0] wr_ptr_r;
    logic [PW:0] rd_ptr_r;
    wire full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
    wire empty = (wr_ptr_r == rd_ptr_r);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr_r[PW-1:0]];
    assign level = wr_ptr_r - rd_ptr_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r[PW-1:0]] <= in_data;
        end
    end

endmodule

/* File: rtl/ddr_burst2_sram_interface.sv */
// burst-of-two double data rate sram device core, link clocks sampled by clk
`timescale 1ns/1ps
// ------------------------------------------------------------
// Function
// - address taken only on alternate K edges
// - write words taken on K and K-bar rises
// - read words launched on K and K-bar rises
// - each address holds exactly two burst words
// - first read word 2.5 cycles after address
// - valid flag high while read data driven
// - echo clocks follow K, controller captures with them
// - shared data pins, driven only for reads
// - every link input sampled through three clk register stages first
// - data outputs come from output registers only
// - array write completes on its own timing
// - only rising edges of both clocks used
// ------------------------------------------------------------
module ddr_burst2_sram_interface (
    input wire logic clk,
    input wire logic resetn,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic load_select_n,
    input wire logic rw_select,
    input wire logic [ddr_pkg::ADDR_W-1:0] addr,
    input wire logic [ddr_pkg::MASK_W-1:0] byte_write_select_n,
    input wire logic [ddr_pkg::DATA_W-1:0] dq_in,
    output logic [ddr_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic echo_strobe,
    output logic echo_strobe_n,
    output logic read_valid_flag,
    output logic write_refused
);
    import ddr_pkg::*;

    localparam int PIN_W = 2 + ADDR_W + MASK_W + DATA_W;

    // ------------------------------------------------------------
    // link clock sampling and edge detection
    // ------------------------------------------------------------
    // third stage only feeds the edge detector, the first is read by the second alone
    logic k_s1_r, k_s2_r, k_s3_r;
    logic kn_s1_r, kn_s2_r, kn_s3_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            k_s1_r <= 1'b0;
            k_s2_r <= 1'b0;
            k_s3_r <= 1'b0;
            kn_s1_r <= 1'b0;
            kn_s2_r <= 1'b0;
            kn_s3_r <= 1'b0;
        end else begin
            k_s1_r <= k_clk;
            k_s2_r <= k_s1_r;
            k_s3_r <= k_s2_r;
            kn_s1_r <= k_clk_n;
            kn_s2_r <= kn_s1_r;
            kn_s3_r <= kn_s2_r;
        end
    end

    // edges stay masked until every sampling stage holds a real pin value:
    // the reset value of a stage need not match the idle level of its pin
    logic [1:0] settle_r;
    wire settled = (settle_r == SYNC_STAGES[1:0]);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            settle_r <= '0;
        end else if (!settled) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    // falling edges are never looked at
    wire k_rise = settled && k_s2_r && !k_s3_r;
    wire kn_rise = settled && kn_s2_r && !kn_s3_r;
    wire k_event = k_rise || kn_rise;

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    // one stage deeper than the clock so that an edge sees the value set up before it
    logic [PIN_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
        end else begin
            pin_s1_r <= {load_select_n, rw_select, addr, byte_write_select_n, dq_in};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    wire [DATA_W-1:0] pin_dq = pin_s3_r[DATA_W-1:0];
    wire [MASK_W-1:0] pin_mask_n = pin_s3_r[DATA_W +: MASK_W];
    wire [ADDR_W-1:0] pin_addr = pin_s3_r[DATA_W+MASK_W +: ADDR_W];
    wire pin_rw = pin_s3_r[PIN_W-2];
    wire pin_load_n = pin_s3_r[PIN_W-1];

    // ------------------------------------------------------------
    // command capture
    // ------------------------------------------------------------
    logic addr_block_r;
    logic rd_cmd_r;
    logic [ADDR_W-1:0] cmd_addr_r;
    logic refused_r;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    logic fifo_in_ready;

    wire cmd_take = k_rise && !pin_load_n && !addr_block_r;
    wire wr_room = fifo_in_ready && (fifo_level <= FIFO_ROOM_MAX[$clog2(FIFO_DEPTH):0]);
    wire rd_take = cmd_take && pin_rw;
    wire wr_take = cmd_take && !pin_rw && wr_room;

    // the K edge after an accepted address is never an address edge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            addr_block_r <= 1'b0;
        end else if (k_rise) begin
            addr_block_r <= cmd_take;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_cmd_r <= 1'b0;
            cmd_addr_r <= '0;
            refused_r <= 1'b0;
        end else begin
            rd_cmd_r <= rd_take;
            refused_r <= cmd_take && !pin_rw && !wr_room;
            if (cmd_take) begin
                cmd_addr_r <= pin_addr;
            end
        end
    end

    assign write_refused = refused_r;

    // ------------------------------------------------------------
    // write data capture
    // ------------------------------------------------------------
    // first word on the K rise after the address, second on the next K-bar rise
    wr_state_e wr_state_r, wr_state_nxt;
    logic push_r;
    logic [ENTRY_W-1:0] entry_r;

    wire take_w0 = k_rise && (wr_state_r == WR_WORD0);
    wire take_w1 = kn_rise && (wr_state_r == WR_WORD1);

    always_comb begin
        wr_state_nxt = wr_state_r;
        unique case (wr_state_r)
            WR_IDLE: begin
                if (wr_take) begin
                    wr_state_nxt = WR_WORD0;
                end
            end
            WR_WORD0: begin
                if (take_w0) begin
                    wr_state_nxt = WR_WORD1;
                end
            end
            WR_WORD1: begin
                if (take_w1) begin
                    wr_state_nxt = WR_IDLE;
                end
            end
            default: begin
                wr_state_nxt = WR_IDLE;
            end
        endcase
    end

    logic [ADDR_W-1:0] wr_addr_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_state_r <= WR_IDLE;
            wr_addr_r <= '0;
        end else begin
            wr_state_r <= wr_state_nxt;
            if (wr_take) begin
                wr_addr_r <= pin_addr;
            end
        end
    end

    // each word becomes one fifo entry with its own byte selects
    always_ff @(posedge clk) begin
        if (!resetn) begin
            push_r <= 1'b0;
            entry_r <= '0;
        end else begin
            push_r <= take_w0 || take_w1;
            if (take_w0 || take_w1) begin
                entry_r <= {take_w1, wr_addr_r, pin_mask_n, pin_dq};
            end
        end
    end

    // ------------------------------------------------------------
    // posted write buffer and self-timed array write
    // ------------------------------------------------------------
    logic drain_valid;
    logic [ENTRY_W-1:0] drain_entry;
    // a read owns the array port in its cycle, so the drain waits
    wire drain_ready = !rd_cmd_r;
    wire drain_fire = drain_valid && drain_ready;

    burst_write_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .in_data(entry_r),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_entry),
        .level(fifo_level)
    );

    logic [DATA_W-1:0] mem [0:MEM_WORDS-1];

    wire [MEM_AW-1:0] drain_idx = {drain_entry[ENT_ADDR_LSB +: ADDR_W], drain_entry[ENT_SEL_BIT]};
    wire [MASK_W-1:0] drain_mask_n = drain_entry[ENT_MASK_LSB +: MASK_W];
    wire [DATA_W-1:0] drain_data = drain_entry[ENT_DATA_LSB +: DATA_W];

    always_ff @(posedge clk) begin
        if (drain_fire) begin
            for (int l = 0; l < MASK_W; l++) begin
                if (!drain_mask_n[l]) begin
                    mem[drain_idx][l*LANE_W +: LANE_W] <= drain_data[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read fetch into a two-deep holding buffer
    // ------------------------------------------------------------
    // a read may start while the previous one is still on the pins
    logic [DATA_W-1:0] rd_w0_r [0:1];
    logic [DATA_W-1:0] rd_w1_r [0:1];
    logic fill_idx_r;
    logic out_idx_r;

    wire [DATA_W-1:0] arr_w0 = mem[{cmd_addr_r, 1'b0}];
    wire [DATA_W-1:0] arr_w1 = mem[{cmd_addr_r, 1'b1}];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fill_idx_r <= 1'b0;
        end else if (rd_cmd_r) begin
            fill_idx_r <= !fill_idx_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rd_cmd_r) begin
            rd_w0_r[fill_idx_r] <= arr_w0;
            rd_w1_r[fill_idx_r] <= arr_w1;
        end
    end

    // ------------------------------------------------------------
    // read latency pipeline in half periods
    // ------------------------------------------------------------
    logic [RD_PIPE_W-1:0] rd_pipe_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_pipe_r <= RD_PIPE_RESET;
        end else if (k_event) begin
            rd_pipe_r <= {rd_pipe_r[RD_PIPE_W-2:0], rd_take};
        end
    end

    wire launch_w0 = kn_rise && rd_pipe_r[RD_LAT_HALF-1];
    wire launch_w1 = k_rise && rd_pipe_r[RD_LAT_HALF];
    wire burst_end = k_event && rd_pipe_r[RD_PIPE_W-1] && !launch_w0;

    // ------------------------------------------------------------
    // output registers and data valid
    // ------------------------------------------------------------
    logic [DATA_W-1:0] dq_out_r;
    logic valid_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dq_out_r <= DQ_RESET;
            out_idx_r <= 1'b0;
        end else if (launch_w0) begin
            dq_out_r <= rd_w0_r[out_idx_r];
        end else if (launch_w1) begin
            dq_out_r <= rd_w1_r[out_idx_r];
            out_idx_r <= !out_idx_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            valid_r <= 1'b0;
        end else if (launch_w0) begin
            valid_r <= 1'b1;
        end else if (burst_end) begin
            valid_r <= 1'b0;
        end
    end

    assign dq_out = dq_out_r;
    // pins driven only across a read burst, released for writes
    assign dq_oe = valid_r;
    assign read_valid_flag = valid_r;

    // ------------------------------------------------------------
    // echo clocks
    // ------------------------------------------------------------
    // launched from the same edge events as the data, so they stay aligned
    logic echo_r;
    logic echo_n_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            echo_r <= 1'b0;
            echo_n_r <= 1'b1;
        end else if (k_rise) begin
            echo_r <= 1'b1;
            echo_n_r <= 1'b0;
        end else if (kn_rise) begin
            echo_r <= 1'b0;
            echo_n_r <= 1'b1;
        end
    end

    assign echo_strobe = echo_r;
    assign echo_strobe_n = echo_n_r;

endmodule

/* File: rtl/ddr_pkg.sv */
// constants shared by the burst-of-two ddr sram device core and its write fifo
package ddr_pkg;

    // ------------------------------------------------------------
    // array geometry: the by-18 organisation, two words per address
    // ------------------------------------------------------------
    localparam int DATA_W = 18;
    localparam int LANE_W = 9;
    localparam int MASK_W = 2;
    localparam int ADDR_W = 19;
    localparam int WORDS_PER_ADDR = 2;
    localparam int MEM_AW = ADDR_W + 1;
    localparam int MEM_WORDS = 1 << MEM_AW;

    // ------------------------------------------------------------
    // write fifo entry: word select, address, byte selects, data
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 32;
    localparam int ENTRY_W = 1 + ADDR_W + MASK_W + DATA_W;
    localparam int ENT_DATA_LSB = 0;
    localparam int ENT_MASK_LSB = DATA_W;
    localparam int ENT_ADDR_LSB = DATA_W + MASK_W;
    localparam int ENT_SEL_BIT = DATA_W + MASK_W + ADDR_W;
    // a write needs room for both words before it is accepted
    localparam int FIFO_ROOM_MAX = FIFO_DEPTH - WORDS_PER_ADDR;

    // ------------------------------------------------------------
    // timing; the read pipeline counted in link clock half periods (edge events)
    // ------------------------------------------------------------
    localparam real READ_LATENCY_CYC = 2.5;
    localparam int RD_LAT_HALF = int'(READ_LATENCY_CYC * 2.0);
    localparam int RD_PIPE_W = RD_LAT_HALF + WORDS_PER_ADDR;
    localparam int SYNC_STAGES = 3;
    localparam real CLK_PERIOD_NS = 8.0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] DQ_RESET = 18'h00000;
    localparam logic [RD_PIPE_W-1:0] RD_PIPE_RESET = '0;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_WORD0 = 2'b01,
        WR_WORD1 = 2'b11
    } wr_state_e;

endpackage

/* File: tb/ddr_burst2_sram_interface_checker.sv */
// port-level assertions for the burst-of-two sram device core
`timescale 1ns/1ps
module sram_if_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ddr_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic echo_strobe,
    input wire logic echo_strobe_n,
    input wire logic read_valid_flag,
    input wire logic write_refused
);
    import ddr_pkg::*;
    logic [4:0] vcnt_r;
    logic [4:0] ecnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    always_ff @(posedge clk) begin
        vcnt_r <= (!resetn || !read_valid_flag) ? 5'h00 : vcnt_r + 5'h01;
        ecnt_r <= (!resetn || $changed(echo_strobe)) ? 5'h00 : ecnt_r + 5'h01;
    end
    echo_pair_a: assert property (echo_strobe_n == !echo_strobe)
        else $error("echo strobes not complementary");
    oe_valid_a: assert property (dq_oe == read_valid_flag)
        else $error("output enable differs from valid flag");
    valid_len_a: assert property ($rose(read_valid_flag) |-> read_valid_flag[*8])
        else $error("valid window shorter than a burst");
    valid_max_a: assert property (vcnt_r <= 5'h12)
        else $error("valid flag held too long");
    echo_hold_a: assert property ($changed(echo_strobe) |=> $stable(echo_strobe)[*5])
        else $error("echo toggles faster than a half period");
    echo_live_a: assert property (ecnt_r <= 5'h0C)
        else $error("echo strobe stopped");
    word0_phase_a: assert property ($rose(read_valid_flag) |-> !echo_strobe)
        else $error("first read word not on the mid-period rise");
    valid_end_a: assert property ($fell(read_valid_flag) |-> !echo_strobe)
        else $error("valid flag fell off the mid-period rise");
    word_hold_a: assert property (read_valid_flag && $past(read_valid_flag)
        && $changed(dq_out) |-> $changed(echo_strobe)
        || $past(echo_strobe) != $past(echo_strobe, 2))
        else $error("read word changed between link edges");
    refused_pulse_a: assert property (write_refused |=> !write_refused)
        else $error("refusal pulse longer than one cycle");
endmodule
bind ddr_burst2_sram_interface sram_if_checker u_sram_if_checker (.clk(clk), .resetn(resetn),
    .dq_out(dq_out), .dq_oe(dq_oe), .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n),
    .read_valid_flag(read_valid_flag), .write_refused(write_refused));

/* File: tb/sram_ctrl_model.sv */
// memory controller model: link clock pair, commands and write bursts
`timescale 1ns/1ps
module sram_ctrl_model (
    output logic k_clk,
    output logic k_clk_n,
    output logic load_select_n,
    output logic rw_select,
    output logic [ddr_pkg::ADDR_W-1:0] addr,
    output logic [ddr_pkg::MASK_W-1:0] byte_write_select_n,
    output logic [ddr_pkg::DATA_W-1:0] ctrl_dq,
    output logic ctrl_oe
);
    import ddr_pkg::*;
    initial begin
        k_clk = 1'b0;
        load_select_n = 1'b1;
        rw_select = 1'b1;
        addr = '0;
        byte_write_select_n = 2'h3;
        ctrl_dq = '0;
        ctrl_oe = 1'b0;
    end
    // slow link for simulation; the pair itself runs free like a real controller
    // limitation: the rate sits far below the operating band, only the ratios are kept
    always #62.5 k_clk = ~k_clk;
    assign k_clk_n = ~k_clk;
    // released pins keep changing so a stale word never passes for data
    always @(posedge k_clk or posedge k_clk_n) begin
        if (!ctrl_oe) ctrl_dq = ~ctrl_dq;
    end
    // pins change mid half-period: 31 ns setup and hold around every rise
    task automatic issue(input logic rd, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] w0, input logic [DATA_W-1:0] w1,
        input logic [MASK_W-1:0] b0, input logic [MASK_W-1:0] b1,
        input bit stray, output realtime t0);
        @(posedge k_clk);
        #31;
        load_select_n = 1'b0;
        rw_select = rd;
        addr = a;
        @(posedge k_clk);
        t0 = $realtime;
        #31;
        load_select_n = !stray;
        rw_select = 1'b1;
        addr = ~a;
        // pins taken over only after a read burst ahead has let go of them
        @(posedge k_clk_n);
        #31;
        if (!rd) begin
            ctrl_oe = 1'b1;
            ctrl_dq = w0;
            byte_write_select_n = b0;
        end
        @(posedge k_clk);
        #31;
        load_select_n = 1'b1;
        if (!rd) ctrl_dq = w1;
        byte_write_select_n = b1;
        @(posedge k_clk_n);
        #31;
        ctrl_oe = 1'b0;
        byte_write_select_n = 2'h3;
    endtask
endmodule

/* File: tb/test_ddr_burst2_sram_interface.sv */
// self-checking bench for the burst-of-two sram device core
`timescale 1ns/1ps
module test_ddr_burst2_sram_interface;
    import ddr_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic k_clk, k_clk_n, load_select_n, rw_select, ctrl_oe, dq_oe;
    logic echo_strobe, echo_strobe_n, read_valid_flag, write_refused;
    logic [ADDR_W-1:0] addr;
    logic [MASK_W-1:0] byte_write_select_n;
    logic [DATA_W-1:0] ctrl_dq, dq_out, dq_in;
    logic [DATA_W-1:0] ref_mem [logic [MEM_AW-1:0]];
    logic [DATA_W-1:0] exp_q [$];
    realtime lat_q [$];
    realtime lt;
    logic [31:0] seed = 32'h6083;
    logic vld_q = 1'b0, echo_q = 1'b0, trig_q = 1'b0, rise_q = 1'b0;
    int err_count = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    // shared pin: device drives while enabled, else the controller
    assign dq_in = dq_oe ? dq_out : ctrl_dq;
    ddr_burst2_sram_interface u_ddr_burst2_sram_interface (.clk(clk), .resetn(resetn),
        .k_clk(k_clk), .k_clk_n(k_clk_n), .load_select_n(load_select_n),
        .rw_select(rw_select), .addr(addr), .byte_write_select_n(byte_write_select_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_strobe(echo_strobe),
        .echo_strobe_n(echo_strobe_n), .read_valid_flag(read_valid_flag),
        .write_refused(write_refused));
    sram_ctrl_model u_sram_ctrl_model (.k_clk(k_clk), .k_clk_n(k_clk_n),
        .load_select_n(load_select_n), .rw_select(rw_select), .addr(addr),
        .byte_write_select_n(byte_write_select_n), .ctrl_dq(ctrl_dq), .ctrl_oe(ctrl_oe));
    // ----------------------------------------
    // reference functions and checks
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] nw, input logic [MASK_W-1:0] b);
        for (int l = 0; l < MASK_W; l++) begin
            if (!b[l]) old[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
        end
        return old;
    endfunction
    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w0,
        input logic [DATA_W-1:0] w1, input logic [MASK_W-1:0] b0, input logic [MASK_W-1:0] b1);
        realtime t;
        for (int j = 0; j < 2; j++) begin
            if (!ref_mem.exists({a, j[0]})) ref_mem[{a, j[0]}] = '0;
        end
        ref_mem[{a, 1'b0}] = merge(ref_mem[{a, 1'b0}], w0, b0);
        ref_mem[{a, 1'b1}] = merge(ref_mem[{a, 1'b1}], w1, b1);
        u_sram_ctrl_model.issue(1'b0, a, w0, w1, b0, b1, 1'b0, t);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input bit stray);
        realtime t;
        exp_q.push_back(ref_mem[{a, 1'b0}]);
        exp_q.push_back(ref_mem[{a, 1'b1}]);
        u_sram_ctrl_model.issue(1'b1, a, '0, '0, 2'h3, 2'h3, stray, t);
        lat_q.push_back(t);
    endtask
    // words are taken two cycles after the echo strobe flips, as a controller would
    always @(posedge clk) begin
        if (dq_oe === 1'b1) check_flag(ctrl_oe, 1'b0);
        if (write_refused !== 1'b0 && resetn) check_flag(write_refused, 1'b0);
        if (trig_q) begin
            if (exp_q.size() == 0) begin
                check_flag(1'b0, 1'b1);
            end else begin
                check_word(dq_out, exp_q.pop_front());
            end
            if (rise_q && lat_q.size() > 0) begin
                lt = $realtime - lat_q.pop_front();
                check_flag(lt >= 312.5 && lt <= 380.0, 1'b1);
            end
        end
        trig_q <= read_valid_flag === 1'b1 && (vld_q !== 1'b1 || echo_strobe !== echo_q);
        rise_q <= read_valid_flag === 1'b1 && vld_q !== 1'b1;
        vld_q <= read_valid_flag;
        echo_q <= echo_strobe;
    end
    initial begin
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] w0, w1;
        repeat (5) @(posedge clk);
        check_flag(dq_oe, 1'b0);
        check_flag(echo_strobe_n, 1'b1);
        #1 resetn = 1'b1;
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            a = seed[ADDR_W-1:0];
            if (i == 0) a = '0;
            if (i == 1) a = '1;
            seed = lfsr(seed);
            w0 = seed[DATA_W-1:0];
            seed = lfsr(seed);
            w1 = seed[DATA_W-1:0];
            wr(a, w0, w1, 2'h0, 2'h0);
            seed = lfsr(seed);
            wr(a, ~w1, ~w0, seed[1:0], seed[3:2]);
            rd(a, i == 5 || i == 9);
            if (i[0]) rd(a, 1'b0);
        end
        for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge clk);
        check_flag(exp_q.size() == 0, 1'b1);
        repeat (60) @(posedge clk);
        wrap_up();
    end
endmodule
